// *** core/irq_bank_map.svh ***
/*
  register offsets, reset values and field sizes of the interrupt enable and pending bank.
  assumes a 32-bit apb slave with word-aligned registers.
*/
`ifndef IRQ_BANK_MAP_SVH
`define IRQ_BANK_MAP_SVH

// ==========================================================
// register offsets (byte addresses)
`define OFS_ENABLE_SET 12'h000
`define OFS_ENABLE_CLEAR 12'h004
`define OFS_PENDING_SET 12'h008
`define OFS_PENDING_CLEAR 12'h00C
`define OFS_ACTIVE 12'h010
`define OFS_EVT_STATUS 12'h014
`define OFS_EVT_MASK 12'h018

// ==========================================================
// sizes and reset values
`define IRQ_COUNT 32
`define ADDR_BITS 12
`define ENABLE_RESET 32'h00000000
`define PENDING_RESET 32'h00000000
`define EVT_STATUS_RESET 2'h0
`define EVT_MASK_RESET 2'h0
`define EVT_BITS 2
`define EVT_NEW_PENDING 0
`define EVT_BAD_ADDR 1

`endif

// *** core/irq_bank_pkg.sv ***
/*
  types of the interrupt enable and pending bank.
  assumes irq_bank_map.svh supplies the sizes.
*/
`include "irq_bank_map.svh"

package irq_bank_pkg;
  typedef logic [`IRQ_COUNT-1:0] irq_vec_t;
  typedef enum logic [2:0] {reg_en_set, reg_en_clr, reg_pend_set, reg_pend_clr, reg_active, reg_evt_stat,
    reg_evt_mask, reg_none} reg_sel_t;
endpackage

// *** core/irq_enable_pending_bank.sv ***
/*
  per-interrupt enable and pending state for interrupts 0 to 31, reached over apb.
  assumes apb master on clk_sys; irq_source comes from peripherals on other timing and is synchronised here.
*/
`timescale 1ns/10ps
`include "irq_bank_map.svh"

module irq_enable_pending_bank
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`ADDR_BITS-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [`IRQ_COUNT-1:0] irq_source,
  output logic [`IRQ_COUNT-1:0] irq_active,
  output logic irq_event
);

  // ==========================================================
  // address decode
  function automatic irq_bank_pkg::reg_sel_t decode(input logic [`ADDR_BITS-1:0] addr);
    irq_bank_pkg::reg_sel_t sel;
    sel = irq_bank_pkg::reg_none;
    // holes and unaligned offsets decode to none
    unique case (addr)
      `OFS_ENABLE_SET: sel = irq_bank_pkg::reg_en_set;
      `OFS_ENABLE_CLEAR: sel = irq_bank_pkg::reg_en_clr;
      `OFS_PENDING_SET: sel = irq_bank_pkg::reg_pend_set;
      `OFS_PENDING_CLEAR: sel = irq_bank_pkg::reg_pend_clr;
      `OFS_ACTIVE: sel = irq_bank_pkg::reg_active;
      `OFS_EVT_STATUS: sel = irq_bank_pkg::reg_evt_stat;
      `OFS_EVT_MASK: sel = irq_bank_pkg::reg_evt_mask;
      default: sel = irq_bank_pkg::reg_none;
    endcase
    return sel;
  endfunction

  // flag state, next values, decode and write strobes
  irq_bank_pkg::irq_vec_t enable;
  irq_bank_pkg::irq_vec_t pending;
  irq_bank_pkg::irq_vec_t src_meta;
  irq_bank_pkg::irq_vec_t src_sync;
  irq_bank_pkg::irq_vec_t src_prev;
  irq_bank_pkg::irq_vec_t next_enable;
  irq_bank_pkg::irq_vec_t next_pending;
  irq_bank_pkg::irq_vec_t src_rise;
  logic [`EVT_BITS-1:0] evt_status;
  logic [`EVT_BITS-1:0] evt_mask;
  logic [`EVT_BITS-1:0] evt_hit;
  irq_bank_pkg::reg_sel_t sel;
  logic access;
  logic wr;
  logic setup;
  logic wr_enable_set;
  logic wr_enable_clear;
  logic wr_pending_set;
  logic wr_pending_clear;
  logic wr_evt_status;
  logic wr_evt_mask;

  // access phase: one wait-free cycle after setup
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign wr = access && pwrite;
  assign sel = decode(paddr);

  // one write strobe per register except the active register, live in the access phase only
  assign wr_enable_set = wr && sel == irq_bank_pkg::reg_en_set;
  assign wr_enable_clear = wr && sel == irq_bank_pkg::reg_en_clr;
  assign wr_pending_set = wr && sel == irq_bank_pkg::reg_pend_set;
  assign wr_pending_clear = wr && sel == irq_bank_pkg::reg_pend_clr;
  assign wr_evt_status = wr && sel == irq_bank_pkg::reg_evt_stat;
  assign wr_evt_mask = wr && sel == irq_bank_pkg::reg_evt_mask;

  // ==========================================================
  // source synchroniser and edge detect
  // two flops before any logic reads a peripheral level
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      src_meta <= `PENDING_RESET;
      src_sync <= `PENDING_RESET;
    end
    else
    begin
      src_meta <= irq_source;
      src_sync <= src_meta;
    end
  end

  // last synchronised level; resets to the idle low, so a source held high through reset gives one edge after reset
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      src_prev <= `PENDING_RESET;
    end
    else
    begin
      src_prev <= src_sync;
    end
  end

  // one-cycle pulse on each rising source level
  assign src_rise = src_sync & ~src_prev;

  // ==========================================================
  // shared enable flags
  always_comb
  begin
    next_enable = enable;
    // ones act, zeros leave the flag alone
    if (wr_enable_set)
    begin
      next_enable = enable | pwdata;
    end
    else if (wr_enable_clear)
    begin
      next_enable = enable & ~pwdata;
    end
  end

  // one shared flag per interrupt, all off after reset
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      enable <= `ENABLE_RESET;
    end
    else
    begin
      enable <= next_enable;
    end
  end

  // ==========================================================
  // pending flags per interrupt
  // one copy of the update logic per interrupt, bit n for interrupt n
  genvar n;
  generate
    for (n = 0; n < `IRQ_COUNT; n++)
    begin : g_pend
      always_comb
      begin
        next_pending[n] = pending[n];
        // clear first so a same-cycle source edge still wins
        if (wr_pending_clear && pwdata[n])
        begin
          next_pending[n] = 1'b0;
        end
        // software pend, refused while the interrupt is disabled
        if (wr_pending_set && pwdata[n] && enable[n])
        begin
          next_pending[n] = 1'b1;
        end
        // peripheral edge, gated by the same enable
        if (src_rise[n] && enable[n])
        begin
          next_pending[n] = 1'b1;
        end
      end
    end
  endgenerate

  // pending flags; zero at reset for a defined start, software must not count on it
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pending <= `PENDING_RESET;
    end
    else
    begin
      pending <= next_pending;
    end
  end

  // active request lines: pending and enabled
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_active <= `PENDING_RESET;
    end
    else
    begin
      irq_active <= next_pending & next_enable;
    end
  end

  // ==========================================================
  // sticky event status, mask and interrupt line
  // any flag that turns pending this cycle
  assign evt_hit[`EVT_NEW_PENDING] = |(next_pending & ~pending);
  // an access phase to a hole in the map
  assign evt_hit[`EVT_BAD_ADDR] = access && sel == irq_bank_pkg::reg_none;

  // sticky status, write one to clear
  // an event in the clearing cycle survives the clear
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      evt_status <= `EVT_STATUS_RESET;
    end
    else if (wr_evt_status)
    begin
      evt_status <= (evt_status & ~pwdata[`EVT_BITS-1:0]) | evt_hit; // set beats clear
    end
    else
    begin
      evt_status <= evt_status | evt_hit;
    end
  end

  // event mask, plain read and write
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      evt_mask <= `EVT_MASK_RESET;
    end
    else if (wr_evt_mask)
    begin
      evt_mask <= pwdata[`EVT_BITS-1:0];
    end
  end

  // level output; follows the status one cycle later
  // unmasked events only; a masked event stays visible in the status
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_event <= 1'b0;
    end
    else
    begin
      irq_event <= |(evt_status & evt_mask);
    end
  end

  // ==========================================================
  // apb handshake: ready in the cycle after setup, so the access phase is one cycle
  // a hole in the map is answered with an error, never left hanging
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup && sel == irq_bank_pkg::reg_none;
    end
  end

  // read data, captured during setup so it stands through the access phase
  // writes answer zero; between transfers the last word is held
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata <= 32'h00000000;
    end
    else if (setup && pwrite)
    begin
      prdata <= 32'h00000000;
    end
    else if (setup)
    begin
      unique case (sel)
        irq_bank_pkg::reg_en_set: prdata <= enable;
        irq_bank_pkg::reg_en_clr: prdata <= enable;
        irq_bank_pkg::reg_pend_set: prdata <= pending;
        irq_bank_pkg::reg_pend_clr: prdata <= pending;
        irq_bank_pkg::reg_active: prdata <= pending & enable;
        irq_bank_pkg::reg_evt_stat: prdata <= {30'h0, evt_status};
        irq_bank_pkg::reg_evt_mask: prdata <= {30'h0, evt_mask};
        irq_bank_pkg::reg_none: prdata <= 32'h00000000;
      endcase
    end
  end

endmodule

// *** bench/irq_bank_monitor.sv ***
/* port checks of the interrupt enable and pending bank.
   assumes it is bound onto the bank at the foot of this file. */
`timescale 1ns/10ps
module irq_bank_monitor
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] irq_source,
  input wire logic [31:0] irq_active,
  input wire logic irq_event
);
  // ==========
  // bus answers
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  AST_RDY: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  AST_ONE: assert property (pready |=> !pready)
    else $error("ready held too long");
  AST_IDLE: assert property (!psel |-> !pready)
    else $error("ready while idle");
  AST_WRD: assert property (pready && pwrite |-> prdata == 32'h0)
    else $error("read data on write");
  AST_ERR: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_BAD: assert property (pready && paddr > 12'h018 |-> pslverr && prdata == 32'h0)
    else $error("unmapped access accepted");
  // ==========
  // state effects
  AST_CLR: assert property (pready && pwrite && paddr == 12'h004 |=> (irq_active & $past(pwdata)) == 32'h0)
    else $error("cleared enable still active");
  AST_RST: assert property ($rose(rst_n) |-> irq_active == 32'h0 && !irq_event)
    else $error("active after reset");
endmodule
bind irq_enable_pending_bank irq_bank_monitor mon
(
  .clk_sys(clk_sys),
  .rst_n(rst_n),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .irq_source(irq_source),
  .irq_active(irq_active),
  .irq_event(irq_event)
);

// *** bench/irq_source_model.sv ***
/* peripheral request sources behind the bank.
   assumes the bench sets the wanted levels. */
`timescale 1ns/10ps
module irq_source_model
(
  input wire logic clk_sys,
  input wire logic [31:0] want,
  output logic [31:0] irq_source
);
  // ==========
  // levels move just after a rising edge
  initial irq_source = 32'h0;
  always @(posedge clk_sys)
    irq_source <= want;
endmodule

// *** bench/irq_enable_pending_bank_test.sv ***
/* self-checking bench of the interrupt enable and pending bank.
   assumes the bank, its monitor and the source model. */
`timescale 1ns/10ps
`include "irq_bank_map.svh"
module irq_enable_pending_bank_test;
  logic clk_sys = 1'h0;
  logic rst_n = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [31:0] irq_source;
  logic [31:0] irq_active;
  logic irq_event;
  logic [31:0] want = 32'h0;
  logic [31:0] en;
  logic [31:0] r;
  logic [32:0] q[$];
  int mismatches = 0;
  int n_tests = 0;
  // ==========
  // clock and parts
  always #5 clk_sys = ~clk_sys;
  irq_enable_pending_bank DUT
  (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .irq_source(irq_source),
    .irq_active(irq_active),
    .irq_event(irq_event)
  );
  irq_source_model src
  (
    .clk_sys(clk_sys),
    .want(want),
    .irq_source(irq_source)
  );
  task cmp(input logic [32:0] got, input logic [32:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // level of the event line
  task cmp_event(input logic got, input logic exp);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // per-interrupt active lines
  task cmp_active(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // one apb transfer, expectation queued
  task xfer(input logic [11:0] a, input logic w, input logic [31:0] d, input logic [32:0] e);
    int n;
    n = 0;
    q.push_back(e);
    psel <= 1'h1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'h1;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (pready !== 1'h1 && n < 9);
    if (pready !== 1'h1)
    begin
      mismatches++;
      complete_run;
    end
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk_sys);
  endtask
  // pair each answer with the oldest expectation
  always @(posedge clk_sys)
    if (psel && penable && pready === 1'h1)
      cmp({pslverr, prdata}, q.pop_front());
  // ==========
  // main sequence
  initial
  begin
    r = $urandom(32'hDE30F68F);
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'h1;
    xfer(`OFS_ENABLE_CLEAR, 1'h0, 32'h0, 33'h0);
    xfer(`OFS_PENDING_CLEAR, 1'h1, 32'hFFFFFFFF, 33'h0);
    en = $urandom;
    xfer(`OFS_ENABLE_SET, 1'h1, en, 33'h0);
    xfer(`OFS_ENABLE_CLEAR, 1'h0, 32'h0, {1'h0, en});
    xfer(`OFS_ENABLE_SET, 1'h0, 32'h0, {1'h0, en});
    r = $urandom;
    xfer(`OFS_ENABLE_CLEAR, 1'h1, r, 33'h0);
    en = en & ~r;
    xfer(`OFS_ENABLE_CLEAR, 1'h0, 32'h0, {1'h0, en});
    xfer(`OFS_PENDING_SET, 1'h1, 32'hFFFFFFFF, 33'h0);
    xfer(`OFS_PENDING_SET, 1'h1, 32'h0, 33'h0);
    xfer(`OFS_PENDING_SET, 1'h0, 32'h0, {1'h0, en});
    xfer(`OFS_ACTIVE, 1'h0, 32'h0, {1'h0, en});
    cmp_active(irq_active, en);
    r = $urandom;
    xfer(`OFS_PENDING_CLEAR, 1'h1, r, 33'h0);
    xfer(`OFS_PENDING_SET, 1'h0, 32'h0, {1'h0, en & ~r});
    cmp_active(irq_active, en & ~r);
    xfer(`OFS_PENDING_SET, 1'h1, 32'hFFFFFFFF, 33'h0);
    xfer(`OFS_PENDING_CLEAR, 1'h0, 32'h0, {1'h0, en});
    // unmapped access raises a masked then unmasked event
    xfer(12'hFFC, 1'h0, 32'h0, {1'h1, 32'h0});
    cmp_event(irq_event, 1'h0);
    xfer(`OFS_EVT_STATUS, 1'h0, 32'h0, {31'h0, 1'h1, |en});
    xfer(`OFS_EVT_MASK, 1'h1, 32'h2, 33'h0);
    xfer(`OFS_EVT_MASK, 1'h0, 32'h0, 33'h2);
    repeat (2) @(posedge clk_sys);
    cmp_event(irq_event, 1'h1);
    xfer(`OFS_EVT_STATUS, 1'h1, 32'h3, 33'h0);
    repeat (2) @(posedge clk_sys);
    cmp_event(irq_event, 1'h0);
    xfer(`OFS_EVT_STATUS, 1'h0, 32'h0, 33'h0);
    // source edges pend enabled interrupts
    xfer(`OFS_ENABLE_SET, 1'h1, 32'hFFFFFFFF, 33'h0);
    xfer(`OFS_PENDING_CLEAR, 1'h1, 32'hFFFFFFFF, 33'h0);
    r = $urandom;
    want <= r;
    repeat (6) @(posedge clk_sys);
    xfer(`OFS_PENDING_SET, 1'h0, 32'h0, {1'h0, r});
    cmp_active(irq_active, r);
    // a new pending flag raises the line once its event bit is unmasked
    xfer(`OFS_EVT_MASK, 1'h1, 32'h1, 33'h0);
    repeat (2) @(posedge clk_sys);
    cmp_event(irq_event, |r);
    complete_run;
  end
endmodule
